//--- hw/tpw_defines.svh
// Purpose: Offsets, field positions, reset values and codes of the timer
// Assumes: 8-bit register port, byte offsets
// Notes:   Definitions only
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH
// Register offsets
`define TPW_OFF_CTRL      4'h0
`define TPW_OFF_CNT_HI    4'h1
`define TPW_OFF_CNT_LO    4'h2
`define TPW_OFF_MOD_HI    4'h3
`define TPW_OFF_MOD_LO    4'h4
`define TPW_OFF_CH0_CTRL  4'h5
`define TPW_CH_STRIDE     4'h3
`define TPW_OFF_SYSOPT    4'hB
// Control register fields
`define TPW_TOF_BIT       7
`define TPW_CENTER_ALIGNED_PWM_BIT      5
`define TPW_CLK_MSB       4
`define TPW_CLK_LSB       3
`define TPW_PS_MSB        2
`define TPW_PS_LSB        0
// Channel control fields
`define TPW_CHF_BIT       7
`define TPW_MS_MSB        5
`define TPW_MS_LSB        4
`define TPW_ELS_MSB       3
`define TPW_ELS_LSB       2
// Values
`define TPW_RST_BYTE      8'h00
`define TPW_RST_WORD      16'h0000
`define TPW_FREE_TOP      16'hFFFF
`define TPW_CNT_ONE       16'h0001
`endif

//--- hw/tpw_pkg.sv
// Purpose: Types shared by the timer design
// Assumes: Used with tpw_defines.svh
// Notes:   Types only
package tpw_pkg;
	typedef enum logic [1:0] {CLK_OFF, CLK_BUS, CLK_FIXED, CLK_EXT} tpw_clksrc_t;
	typedef enum logic [2:0] {CH_OFF, CH_CAPTURE, CH_COMPARE, CH_EDGE_ALIGNED_PWM, CH_CENTER_ALIGNED_PWM} tpw_chmode_t;
	typedef enum {DIR_UP, DIR_DOWN} tpw_dir_t;
endpackage : tpw_pkg

//--- hw/tpw_timer.sv
// Purpose: 16-bit two-channel timer with capture, compare and PWM
// Assumes: Pin inputs synchronous to MCLK; clocks stop outside in stop mode
// Notes:   Pin outputs lag the channel state by one MCLK cycle
// How it works
// - Per-channel position bit: 0 routes to port A pin, 1 to port B pin.
// - Each channel alone picks capture, compare or edge PWM.
// - One control bit forces every channel with nonzero edge/level bits into center-aligned PWM.
// - Counter holds while background debug is active.
// - Runs in wait; halts with clocks stopped in stop mode.
// - Capture edge copies counter into channel value and sets flag.
// - Capture edge: rising, falling, either, or none disables channel.
// - Compare match sets flag and applies pin action.
// - Compare action: low, high, toggle, or pin untouched.
// - Edge PWM period is modulo plus one; value sets duty.
// - Edge PWM pulses start at period start; polarity selectable.
// - Edge PWM flags at period end and duty transition.
// - Center mode counts up to modulo then down to zero.
// - Center mode: active on down match, inactive on up match.
// - Modulo 0x0000 or 0xFFFF makes counter free-running.
// - Reading the counter never disturbs counting.
// - Writing either counter byte resets it; data ignored.
// - Source bus, fixed or external, then prescale 1 to 128.
// - Fixed clock source is synchronised to the bus clock.
// - One request per channel plus one terminal-count request.
// - After reset no function claims any pin.
// - High-true edge PWM: high at restart, low at match; else inverted.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "tpw_defines.svh"
module tpw_timer
	import tpw_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	input  wire logic                MCLK,
	input  wire logic                RST,
	input  wire logic                CE,
	input  wire logic [3:0]          ADDR,
	input  wire logic [7:0]          WDATA,
	input  wire logic                WR,
	input  wire logic                RD,
	output logic      [7:0]          RDATA,
	input  wire logic                BACKGROUND_DEBUG_MODE,
	input  wire logic                FIXED_CLK,
	input  wire logic                EXTERNAL_COUNT_CLOCK,
	input  wire logic [CHANNELS-1:0] PORT_A_IN,
	output logic      [CHANNELS-1:0] PORT_A_OUT,
	output logic      [CHANNELS-1:0] PORT_A_OE,
	input  wire logic [CHANNELS-1:0] PORT_B_IN,
	output logic      [CHANNELS-1:0] PORT_B_OUT,
	output logic      [CHANNELS-1:0] PORT_B_OE,
	output logic      [CHANNELS-1:0] CHAN_REQ,
	output logic                     TERM_REQ
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [6:0] pre_mask(input logic [2:0] ps);
		pre_mask = 7'((8'h01 << ps) - 8'h01);
	endfunction : pre_mask

	function automatic tpw_chmode_t ch_mode(input logic cp, input logic [1:0] ms,
		input logic [1:0] els);
		if (cp)
			ch_mode = (els == 2'b00) ? CH_OFF : CH_CENTER_ALIGNED_PWM;
		else if (ms[1])
			ch_mode = (els == 2'b00) ? CH_OFF : CH_EDGE_ALIGNED_PWM;
		else if (ms[0])
			ch_mode = CH_COMPARE;
		else
			ch_mode = (els == 2'b00) ? CH_OFF : CH_CAPTURE;
	endfunction : ch_mode

	////////////////////////////////////////////////////////////////////////////
	// State
	logic                          tof;
	logic                          center_aligned_pwm;
	tpw_clksrc_t                   clk_sel;
	logic [2:0]                    ps;
	logic [15:0]                   cnt;
	logic [15:0]                   modv;
	tpw_dir_t                      dir;
	logic [6:0]                    pre;
	logic [2:0]                    sync1;
	logic [2:0]                    sync2;
	logic [2:0]                    sync3;
	logic [CHANNELS-1:0][15:0]     cv;
	logic [CHANNELS-1:0][1:0]      ms;
	logic [CHANNELS-1:0][1:0]      els;
	logic [CHANNELS-1:0]           chf;
	logic [CHANNELS-1:0]           pos;
	logic [CHANNELS-1:0]           chan_out;
	logic [CHANNELS-1:0]           pin_prev;
	logic                          src_tick;
	logic                          tick;
	logic                          wrap;
	logic [15:0]                   top;
	logic [15:0]                   next_cnt;
	tpw_dir_t                      next_dir;
	logic                          cnt_wr;

	assign cnt_wr = WR && (ADDR == `TPW_OFF_CNT_HI || ADDR == `TPW_OFF_CNT_LO);

	////////////////////////////////////////////////////////////////////////////
	// Source selection; the first sync stage feeds only the second
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 3'h0;
		end else if (CE) begin
			sync1 <= {1'b0, EXTERNAL_COUNT_CLOCK, FIXED_CLK};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Rising edge of the chosen source, or every bus cycle
	always_comb begin
		case (clk_sel)
			CLK_BUS:   src_tick = 1'b1;
			CLK_FIXED: src_tick = sync2[0] & ~sync3[0];
			CLK_EXT:   src_tick = sync2[1] & ~sync3[1];
			default:   src_tick = 1'b0;
		endcase
		// Debug halts the count without touching the register contents
		src_tick = src_tick & ~BACKGROUND_DEBUG_MODE;
		tick     = src_tick && ((pre & pre_mask(ps)) == pre_mask(ps));
	end

	// Prescaler; restarts with the counter so phases stay predictable
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			pre <= 7'h00;
		else if (CE) begin
			if (cnt_wr)
				pre <= 7'h00;
			else if (src_tick)
				pre <= pre + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter next value
	always_comb begin
		top = (modv == `TPW_RST_WORD) ? `TPW_FREE_TOP : modv;
		next_cnt = cnt + `TPW_CNT_ONE;
		next_dir = dir;
		wrap = 1'b0;
		if (!center_aligned_pwm) begin
			next_dir = DIR_UP;
			if (cnt == top) begin
				next_cnt = `TPW_RST_WORD;
				wrap = 1'b1;
			end
		end else if (dir == DIR_UP) begin
			if (cnt >= top) begin
				next_cnt = cnt - `TPW_CNT_ONE;
				next_dir = DIR_DOWN;
			end
		end else begin
			next_cnt = cnt - `TPW_CNT_ONE;
			if (cnt <= `TPW_CNT_ONE) begin
				next_cnt = `TPW_RST_WORD;
				next_dir = DIR_UP;
				wrap = 1'b1;
			end
		end
	end

	// Counter; CE low freezes it like stopped clocks in stop mode
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cnt <= `TPW_RST_WORD;
			dir <= DIR_UP;
		end else if (CE) begin
			if (cnt_wr) begin
				cnt <= `TPW_RST_WORD;
				dir <= DIR_UP;
			end else if (tick) begin
				cnt <= next_cnt;
				dir <= next_dir;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Module control and terminal flag; a set wins over a clear
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			tof     <= 1'b0;
			center_aligned_pwm    <= 1'b0;
			clk_sel <= CLK_OFF;
			ps      <= 3'h0;
			modv    <= `TPW_RST_WORD;
			pos     <= '0;
		end else if (CE) begin
			if (WR && ADDR == `TPW_OFF_CTRL) begin
				center_aligned_pwm    <= WDATA[`TPW_CENTER_ALIGNED_PWM_BIT];
				clk_sel <= tpw_clksrc_t'(WDATA[`TPW_CLK_MSB:`TPW_CLK_LSB]);
				ps      <= WDATA[`TPW_PS_MSB:`TPW_PS_LSB];
			end
			if (WR && ADDR == `TPW_OFF_MOD_HI)
				modv[15:8] <= WDATA;
			if (WR && ADDR == `TPW_OFF_MOD_LO)
				modv[7:0] <= WDATA;
			if (WR && ADDR == `TPW_OFF_SYSOPT)
				pos <= WDATA[CHANNELS-1:0];
			if (tick && wrap)
				tof <= 1'b1;
			else if (WR && ADDR == `TPW_OFF_CTRL && WDATA[`TPW_TOF_BIT])
				tof <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channels: configuration, capture, compare and PWM drive
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cv       <= '0;
			ms       <= '0;
			els      <= '0;
			chf      <= '0;
			chan_out <= '0;
			pin_prev <= '0;
		end else if (CE) begin
			for (int n = 0; n < CHANNELS; n++) begin
				logic [3:0]  base;
				logic        pin;
				logic        evt;
				logic        hit;
				logic        act;
				tpw_chmode_t m;
				base = 4'(`TPW_OFF_CH0_CTRL + n * `TPW_CH_STRIDE);
				pin  = pos[n] ? PORT_B_IN[n] : PORT_A_IN[n];
				m    = ch_mode(center_aligned_pwm, ms[n], els[n]);
				hit  = tick && (cnt == cv[n]);
				act  = ~els[n][0];
				evt  = 1'b0;
				pin_prev[n] <= pin;
				// Register writes
				if (WR && ADDR == base) begin
					ms[n]  <= WDATA[`TPW_MS_MSB:`TPW_MS_LSB];
					els[n] <= WDATA[`TPW_ELS_MSB:`TPW_ELS_LSB];
				end
				if (WR && ADDR == base + 4'h1)
					cv[n][15:8] <= WDATA;
				if (WR && ADDR == base + 4'h2)
					cv[n][7:0] <= WDATA;
				case (m)
					CH_CAPTURE: begin
						// Edge against the previous sample of the pin
						evt = (els[n][0] & pin & ~pin_prev[n]) |
						      (els[n][1] & ~pin & pin_prev[n]);
						if (evt)
							cv[n] <= cnt;
					end
					CH_COMPARE: begin
						evt = hit;
						if (hit) begin
							case (els[n])
								2'b01:   chan_out[n] <= ~chan_out[n];
								2'b10:   chan_out[n] <= 1'b0;
								2'b11:   chan_out[n] <= 1'b1;
								default: chan_out[n] <= chan_out[n];
							endcase
						end
					end
					CH_EDGE_ALIGNED_PWM: begin
						evt = hit;
						if (hit)
							chan_out[n] <= ~act;
						else if (tick && cnt == `TPW_RST_WORD)
							chan_out[n] <= act;
					end
					CH_CENTER_ALIGNED_PWM: begin
						evt = hit;
						if (hit)
							chan_out[n] <= (dir == DIR_DOWN) ? act : ~act;
					end
					default: evt = 1'b0;
				endcase
				if (evt)
					chf[n] <= 1'b1;
				else if (WR && ADDR == base && WDATA[`TPW_CHF_BIT])
					chf[n] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin ownership; an idle or unclocked channel leaves pins to the port
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			PORT_A_OUT <= '0;
			PORT_A_OE  <= '0;
			PORT_B_OUT <= '0;
			PORT_B_OE  <= '0;
			CHAN_REQ   <= '0;
			TERM_REQ   <= 1'b0;
		end else if (CE) begin
			for (int n = 0; n < CHANNELS; n++) begin
				logic drv;
				drv = clk_sel != CLK_OFF && els[n] != 2'b00 &&
				      ch_mode(center_aligned_pwm, ms[n], els[n]) != CH_CAPTURE;
				PORT_A_OUT[n] <= chan_out[n];
				PORT_B_OUT[n] <= chan_out[n];
				PORT_A_OE[n]  <= drv & ~pos[n];
				PORT_B_OE[n]  <= drv & pos[n];
			end
			CHAN_REQ <= chf;
			TERM_REQ <= tof;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port; reads have no side effects anywhere
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			RDATA <= `TPW_RST_BYTE;
		else if (CE) begin
			RDATA <= `TPW_RST_BYTE;
			if (RD) begin
				case (ADDR)
					`TPW_OFF_CTRL:   RDATA <= {tof, 1'b0, center_aligned_pwm, clk_sel, ps};
					`TPW_OFF_CNT_HI: RDATA <= cnt[15:8];
					`TPW_OFF_CNT_LO: RDATA <= cnt[7:0];
					`TPW_OFF_MOD_HI: RDATA <= modv[15:8];
					`TPW_OFF_MOD_LO: RDATA <= modv[7:0];
					`TPW_OFF_SYSOPT: RDATA <= 8'(pos);
					default: begin
						for (int n = 0; n < CHANNELS; n++) begin
							if (ADDR == 4'(`TPW_OFF_CH0_CTRL + n * `TPW_CH_STRIDE))
								RDATA <= {chf[n], 1'b0, ms[n], els[n], 2'b00};
							if (ADDR == 4'(`TPW_OFF_CH0_CTRL + n * `TPW_CH_STRIDE + 1))
								RDATA <= cv[n][15:8];
							if (ADDR == 4'(`TPW_OFF_CH0_CTRL + n * `TPW_CH_STRIDE + 2))
								RDATA <= cv[n][7:0];
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_cnt_write_reset: assert property (@(posedge MCLK) disable iff (RST || !CE)
		cnt_wr |=> cnt == `TPW_RST_WORD) else $error("counter write did not reset");
	a_cnt_debug_hold: assert property (@(posedge MCLK) disable iff (RST || !CE)
		BACKGROUND_DEBUG_MODE && !cnt_wr |=> $stable(cnt))
		else $error("counter moved in debug");
	a_up_wrap_zero: assert property (@(posedge MCLK) disable iff (RST || !CE)
		tick && !center_aligned_pwm && !cnt_wr && cnt == top |=> cnt == `TPW_RST_WORD && tof)
		else $error("up count did not wrap at top");
	a_free_run_top: assert property (@(posedge MCLK) disable iff (RST || !CE)
		tick && !center_aligned_pwm && !cnt_wr && (modv == `TPW_RST_WORD || modv == `TPW_FREE_TOP)
		|=> cnt == $past(cnt) + `TPW_CNT_ONE) else $error("free run count skipped");
	a_center_turn_down: assert property (@(posedge MCLK) disable iff (RST || !CE)
		tick && center_aligned_pwm && !cnt_wr && dir == DIR_UP && cnt == top
		|=> dir == DIR_DOWN && cnt == $past(top) - `TPW_CNT_ONE)
		else $error("center count did not turn");
	a_capture_copy: assert property (@(posedge MCLK) disable iff (RST || !CE)
		ch_mode(center_aligned_pwm, ms[0], els[0]) == CH_CAPTURE && els[0] == 2'b01 && !pos[0] && !WR
		&& PORT_A_IN[0] && !pin_prev[0] |=> cv[0] == $past(cnt) && chf[0])
		else $error("capture lost");
	a_compare_flag: assert property (@(posedge MCLK) disable iff (RST || !CE)
		ch_mode(center_aligned_pwm, ms[0], els[0]) == CH_COMPARE && tick && cnt == cv[0]
		|=> chf[0] ##1 CHAN_REQ[0]) else $error("compare flag missing");
	a_edge_aligned_pwm_match_low: assert property (@(posedge MCLK) disable iff (RST || !CE)
		ch_mode(center_aligned_pwm, ms[0], els[0]) == CH_EDGE_ALIGNED_PWM && els[0] == 2'b10 && tick && cnt == cv[0]
		|=> !chan_out[0]) else $error("edge pwm did not fall at match");
	a_center_aligned_pwm_down_active: assert property (@(posedge MCLK) disable iff (RST || !CE)
		ch_mode(center_aligned_pwm, ms[1], els[1]) == CH_CENTER_ALIGNED_PWM && tick && cnt == cv[1] && dir == DIR_DOWN
		|=> chan_out[1] == ~$past(els[1][0])) else $error("center pwm not active");
	a_route_select: assert property (@(posedge MCLK) disable iff (RST || !CE)
		##1 !(PORT_A_OE[0] && PORT_B_OE[0])) else $error("channel drives two pins");

endmodule : tpw_timer

//--- verification/tpw_pin_board.sv
// Purpose: Board circuitry on the timer channel pins and count clock inputs
// Assumes: Each pin has a pull-up; the bench may drive a pin the timer leaves
// Notes:   Pin order is {B1, B0, A1, A0}
`timescale 1ns/10ps
module tpw_pin_board (
	input  wire logic       mclk,
	input  wire logic [3:0] pin_out,
	input  wire logic [3:0] pin_oe,
	input  wire logic [3:0] drv_en,
	input  wire logic [3:0] drv_val,
	output logic      [3:0] pin_in,
	output logic            slow_clk
);
	logic [2:0] div = 3'h0;
	////////////////////////////////////////
	// Timer drive wins, then the bench driver, else the pull-up holds it high
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : (drv_en[i] ? drv_val[i] : 1'b1);
		end
	end
	////////////////////////////////////////
	// Period of 8 MCLK, half the quarter-rate limit, so sampler jitter is harmless
	always_ff @(posedge mclk) begin
		div <= div + 3'h1;
	end
	assign slow_clk = div[2];
endmodule : tpw_pin_board

//--- verification/tpw_timer_tb.sv
// Purpose: Self-checking bench for the two-channel timer
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Counter is frozen by debug hold where an exact count value is compared; rate checks rely on exact timing
`timescale 1ns/10ps
`include "tpw_defines.svh"
module tpw_timer_tb;
	logic        MCLK = 1'b0;
	logic        RST = 1'b1;
	logic        WR = 1'b0;
	logic        RD = 1'b0;
	logic [3:0]  ADDR = 4'h0;
	logic [7:0]  WDATA = 8'h00;
	logic        BACKGROUND_DEBUG_MODE = 1'b0;
	logic        CE = 1'b1;
	logic [7:0]  RDATA;
	logic [1:0]  PORT_A_OUT, PORT_A_OE, PORT_B_OUT, PORT_B_OE, CHAN_REQ;
	logic        TERM_REQ;
	logic [3:0]  pin_in;
	logic        slow_clk;
	logic [3:0]  drv_en = 4'h1;
	logic [3:0]  drv_val = 4'h0;
	int          n_fail = 0;
	int          checked = 0;
	logic [7:0]  ctl [6] = '{8'h08, 8'h0B, 8'h0C, 8'h10, 8'h18, 8'h08};
	logic [7:0]  dlt [6] = '{8'hF0, 8'h1E, 8'h0F, 8'h1E, 8'h1E, 8'hF0};
	logic [15:0] top [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF};
	////////////////////////////////////////
	tpw_timer #(.CHANNELS(2)) dut (
		.MCLK(MCLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .BACKGROUND_DEBUG_MODE(BACKGROUND_DEBUG_MODE),
		.FIXED_CLK(slow_clk), .EXTERNAL_COUNT_CLOCK(slow_clk),
		.PORT_A_IN(pin_in[1:0]), .PORT_A_OUT(PORT_A_OUT), .PORT_A_OE(PORT_A_OE),
		.PORT_B_IN(pin_in[3:2]), .PORT_B_OUT(PORT_B_OUT), .PORT_B_OE(PORT_B_OE),
		.CHAN_REQ(CHAN_REQ), .TERM_REQ(TERM_REQ));
	tpw_pin_board board (
		.mclk(MCLK), .pin_out({PORT_B_OUT, PORT_A_OUT}), .pin_oe({PORT_B_OE, PORT_A_OE}),
		.drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in), .slow_clk(slow_clk));
	////////////////////////////////////////
	// Clock and watchdog; the whole run needs well under 5000 cycles
	initial begin
		forever #20 MCLK = ~MCLK;
	end
	initial begin
		repeat (20000) @(posedge MCLK);
		n_fail++;
		tally_and_finish();
	end
	////////////////////////////////////////
	task automatic tally_and_finish;
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Step n edges, then let their updates settle before sampling
	task automatic tick(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge MCLK);
		WR    <= 1'b1;
		ADDR  <= a;
		WDATA <= d;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge MCLK);
		RD   <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask : rd
	// Halves are independent bytes; only coherent while the counter is held
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		rd(a, v[15:8]);
		rd(a + 4'h1, v[7:0]);
	endtask : rd16
	task automatic w16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 4'h1, v[7:0]);
	endtask : w16
	task automatic set_pin(input logic v);
		@(posedge MCLK);
		drv_val[0] <= v;
		tick(6);
	endtask : set_pin
	task automatic hold(input logic v);
		@(posedge MCLK);
		BACKGROUND_DEBUG_MODE <= v;
	endtask : hold
	// Count high cycles of both channel pins, and of channel 0 high alone
	task automatic duty(input int n, output logic [15:0] o0, o1, sk);
		o0 = 16'h0000;
		o1 = 16'h0000;
		sk = 16'h0000;
		repeat (n) begin
			tick(1);
			o0 = o0 + {15'h0000, PORT_A_OUT[0]};
			o1 = o1 + {15'h0000, PORT_A_OUT[1]};
			sk = sk + {15'h0000, PORT_A_OUT[0] & ~PORT_A_OUT[1]};
		end
	endtask : duty
	////////////////////////////////////////
	initial begin
		logic [7:0]  b;
		logic [7:0]  c;
		logic [15:0] v;
		logic [15:0] w;
		logic [15:0] o0;
		logic [15:0] o1;
		logic [15:0] sk;
		logic [1:0]  e;
		logic        x;
		repeat (5) @(posedge MCLK);
		RST <= 1'b0;
		tick(1);
		chk({9'h000, PORT_A_OE, PORT_B_OE, CHAN_REQ, TERM_REQ}, 16'h0000, "idle pins");
		rd(`TPW_OFF_SYSOPT, b);
		chk({8'h00, b}, 16'h0000, "position");
		wr(4'hC, 8'hFF);
		rd(4'hC, b);
		chk({8'h00, b}, 16'h0000, "unmapped");
		// Count rate over exactly 240 cycles for each source, and for dividers 1, 8 and 16 on the bus clock
		for (int i = 0; i < 6; i++) begin
			w16(`TPW_OFF_MOD_HI, top[i]);
			wr(`TPW_OFF_CTRL, ctl[i]);
			tick(40);
			rd(`TPW_OFF_CNT_LO, b);
			repeat (238) @(posedge MCLK);
			rd(`TPW_OFF_CNT_LO, c);
			chk({8'h00, c - b}, {8'h00, dlt[i]}, "count rate");
		end
		// Enable low for 20 edges stands in for stopped clocks; 3 counts survive
		rd(`TPW_OFF_CNT_LO, b);
		@(posedge MCLK);
		CE <= 1'b0;
		repeat (20) @(posedge MCLK);
		CE <= 1'b1;
		rd(`TPW_OFF_CNT_LO, c);
		chk({8'h00, c - b}, 16'h0003, "frozen count");
		hold(1'b1);
		tick(3);
		rd16(`TPW_OFF_CNT_HI, v);
		tick(10);
		rd16(`TPW_OFF_CNT_HI, w);
		chk(w, v, "held count");
		wr(`TPW_OFF_CNT_HI, 8'h5A);
		rd16(`TPW_OFF_CNT_HI, w);
		chk(w, 16'h0000, "clear by high");
		hold(1'b0);
		tick(50);
		hold(1'b1);
		tick(3);
		rd16(`TPW_OFF_CNT_HI, v);
		chk({15'h0000, v > 16'h0020 && v < 16'h0040}, 16'h0001, "resumed");
		// Capture with the counter held, so the captured value is known
		for (int i = 0; i < 4; i++) begin
			e = 2'(i);
			wr(`TPW_OFF_CH0_CTRL, {4'h8, e, 2'h0});
			set_pin(1'b1);
			rd(`TPW_OFF_CH0_CTRL, b);
			chk({15'h0000, b[7]}, {15'h0000, e[0]}, "rise capture");
			wr(`TPW_OFF_CH0_CTRL, {4'h8, e, 2'h0});
			set_pin(1'b0);
			chk({14'h0000, CHAN_REQ}, {15'h0000, e[1]}, "fall request");
			rd16(`TPW_OFF_CH0_CTRL + 4'h1, w);
			chk(w, (e == 2'h0) ? 16'h0000 : v, "capture value");
		end
		wr(`TPW_OFF_CNT_LO, 8'hFF);
		rd16(`TPW_OFF_CNT_HI, w);
		chk(w, 16'h0000, "clear by low");
		hold(1'b0);
		// Output compare: set on the alternate pin, then clear, toggle, software
		w16(`TPW_OFF_MOD_HI, 16'h0010);
		w16(`TPW_OFF_CH0_CTRL + 4'h1, 16'h0005);
		wr(`TPW_OFF_CH0_CTRL, 8'h9C);
		wr(`TPW_OFF_SYSOPT, 8'h01);
		tick(40);
		chk({13'h0000, PORT_B_OE[0], PORT_A_OE[0], PORT_B_OUT[0]}, 16'h0005, "set on B");
		rd(`TPW_OFF_CH0_CTRL, b);
		chk({15'h0000, b[7]}, 16'h0001, "match flag");
		wr(`TPW_OFF_SYSOPT, 8'h00);
		wr(`TPW_OFF_CH0_CTRL, 8'h98);
		tick(40);
		chk({14'h0000, PORT_A_OE[0], PORT_A_OUT[0]}, 16'h0002, "clear on A");
		wr(`TPW_OFF_CH0_CTRL, 8'h94);
		tick(20);
		x = PORT_A_OUT[0];
		tick(17);
		chk({15'h0000, PORT_A_OUT[0]}, {15'h0000, ~x}, "toggle");
		wr(`TPW_OFF_CH0_CTRL, 8'h90);
		tick(40);
		chk({14'h0000, PORT_A_OE[0], CHAN_REQ[0]}, 16'h0001, "software only");
		// Edge PWM, period 10, duties 3 and 6
		w16(`TPW_OFF_MOD_HI, 16'h0009);
		wr(`TPW_OFF_CNT_HI, 8'h00);
		w16(`TPW_OFF_CH0_CTRL + 4'h1, 16'h0003);
		w16(`TPW_OFF_CH0_CTRL + 4'h4, 16'h0006);
		wr(`TPW_OFF_CH0_CTRL, 8'hA8);
		wr(`TPW_OFF_CH0_CTRL + 4'h3, 8'hA8);
		tick(30);
		duty(10, o0, o1, sk);
		chk(o0, 16'h0003, "edge duty 0");
		chk(o1, 16'h0006, "edge duty 1");
		chk(sk, 16'h0000, "common start");
		chk({14'h0000, TERM_REQ, CHAN_REQ[1]}, 16'h0003, "edge flags");
		wr(`TPW_OFF_CH0_CTRL, 8'hA4);
		tick(30);
		duty(10, o0, o1, sk);
		chk(o0, 16'h0007, "low-true duty");
		// Center PWM, period 16; channel 1 set up as capture is still forced to PWM
		wr(`TPW_OFF_CTRL, 8'hA8);
		w16(`TPW_OFF_MOD_HI, 16'h0008);
		wr(`TPW_OFF_CNT_HI, 8'h00);
		w16(`TPW_OFF_CH0_CTRL + 4'h1, 16'h0005);
		w16(`TPW_OFF_CH0_CTRL + 4'h4, 16'h0002);
		wr(`TPW_OFF_CH0_CTRL, 8'h08);
		wr(`TPW_OFF_CH0_CTRL + 4'h3, 8'h04);
		tick(40);
		duty(16, o0, o1, sk);
		chk(o0, 16'h000A, "center duty");
		chk(o1, 16'h000C, "center forced");
		chk({13'h0000, PORT_A_OE, TERM_REQ}, 16'h0007, "center drive");
		// Terminal flag clears by a one written while the counter is held
		hold(1'b1);
		wr(`TPW_OFF_CTRL, 8'hA8);
		tick(3);
		rd(`TPW_OFF_CTRL, b);
		chk({14'h0000, b[7], TERM_REQ}, 16'h0000, "end flag clear");
		tally_and_finish();
	end
endmodule : tpw_timer_tb
